// ---- src/branch_bitset_pkg.sv ----
package branch_bitset_pkg;
   // opcode fields of the four instructions
   localparam logic [3:0] op_hi_cond = 4'he; // conditional branch top nibble
   localparam logic [3:0] op_carry_clr = 4'h3; // second nibble, carry test
   localparam logic [3:0] op_neg_clr = 4'h7; // second nibble, negative test
   localparam logic [4:0] op_bra_pfx = 5'h1a; // 1101 then 0
   localparam logic [3:0] op_bitset = 4'h8; // bit-set prefix
   localparam int pos_bit_hi = 11; // bit number field top
   localparam int pos_bit_lo = 9; // bit number field bottom
   localparam int pos_access = 8; // access bit position
   localparam logic [7:0] idx_limit = 8'h5f; // indexed literal offset upper address
   localparam logic [3:0] access_hi_bank = 4'hf; // access bank upper half bank
   localparam logic [7:0] access_split = 8'h60; // access bank split point
   localparam logic [20:0] pc_step = 21'h000002; // one instruction word in bytes
   localparam logic [20:0] pc_reset = 21'h000000; // program counter after reset
   localparam logic [1:0] q_last = 2'h3; // last quarter phase index, q4
   typedef enum logic [1:0] {st_exec, st_nop} exec_state_t;
endpackage

// ---- src/bit_set_unit.sv ----
`timescale 1ns/1ps
`default_nettype none
// read-modify-write of one register bit, staged over q2..q4
module bit_set_unit
   import branch_bitset_pkg::*;
(
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic start_in, // pulse in q2 of a bit-set cycle
   input wire logic [1:0] quarter_in, // current quarter phase
   input wire logic [2:0] bit_sel_in, // bit to set
   input wire logic [7:0] rd_data_in, // data read from the addressed register
   output logic rd_en_out, // read strobe, q2
   output logic wr_en_out, // write strobe, q4
   output logic [7:0] wr_data_out // modified byte
);
   typedef struct packed {
      logic busy; // instruction in flight
      logic [2:0] bsel; // latched bit number
      logic [7:0] data; // byte being modified
      logic wr; // write strobe
   } rmw_t;
   rmw_t cur_ff, nxt_cur;

   // one-hot mask of the chosen bit
   function automatic logic [7:0] bit_mask(input logic [2:0] b);
      bit_mask = 8'h01 << b;
   endfunction

   // stage progression across quarters; start arrives in q2 with the read strobe
   always_comb begin
      nxt_cur = cur_ff;
      nxt_cur.wr = 1'b0;
      if (start_in) begin
         nxt_cur.busy = 1'b1;
         nxt_cur.bsel = bit_sel_in;
         nxt_cur.data = rd_data_in; // capture read value at the end of q2
      end else if (cur_ff.busy && quarter_in == 2'h2) begin
         nxt_cur.data = cur_ff.data | bit_mask(cur_ff.bsel); // modify in q3
         nxt_cur.wr = 1'b1; // write back in q4
      end else if (cur_ff.busy && quarter_in == q_last) begin
         nxt_cur.busy = 1'b0;
      end
   end

   // state register
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         cur_ff <= '0;
      end else begin
         cur_ff <= nxt_cur;
      end
   end

   // read strobe is the start pulse itself, so it stands for the whole of q2
   assign rd_en_out = start_in;
   assign wr_en_out = cur_ff.wr;
   assign wr_data_out = cur_ff.data;

   // write back is the read value with only the chosen bit forced high
   chk_rmw_single_bit: assert property (@(posedge clk_in) disable iff (!resetn_in)
      cur_ff.wr |-> (cur_ff.data == ($past(rd_data_in, 2) | bit_mask(cur_ff.bsel))))
      else $error("bit-set wrote wrong byte");
   // read strobe followed by write strobe two quarters later
   chk_rmw_order: assert property (@(posedge clk_in) disable iff (!resetn_in)
      rd_en_out |-> ##2 wr_en_out)
      else $error("bit-set write not two quarters after read");
endmodule // bit_set_unit
`default_nettype wire

// ---- src/branch_bitset_exec.sv ----
`timescale 1ns/1ps
`default_nettype none
module branch_bitset_exec
   import branch_bitset_pkg::*;
(
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic [15:0] instr_in, // instruction word, valid in q1
   input wire logic instr_valid_in, // instruction present this cycle
   input wire logic carry_in, // carry status flag
   input wire logic negative_in, // negative status flag
   input wire logic ext_set_in, // extended instruction set enabled
   input wire logic [3:0] bank_select_value_in, // bank select register
   input wire logic [11:0] index_base_in, // indexed pointer base
   input wire logic [7:0] rd_data_in, // data memory read value
   output logic [20:0] pc_out, // program counter
   output logic [1:0] quarter_out, // current quarter phase
   output logic nop_cycle_out, // second cycle of a taken branch
   output logic [11:0] data_addr_out, // data memory address
   output logic rd_en_out, // data memory read strobe
   output logic wr_en_out, // data memory write strobe
   output logic [7:0] wr_data_out, // data memory write value
   output logic status_we_out // status write, held low
);
   typedef struct packed {
      exec_state_t st; // executing or forced nop
      logic [1:0] q; // quarter counter
      logic [20:0] pc; // program counter
      logic [20:0] here; // address of instruction in decode
      logic [20:0] target; // computed branch target
      logic take; // branch decision
      logic [11:0] addr; // latched data address
      logic bs_start; // kick the bit-set unit
      logic [2:0] bsel; // latched bit number
      logic [10:0] offs; // word offset of the branch in decode
   } core_t;
   core_t cur_ff, nxt_cur;

   // sign-extend word offset, double it, add to pc plus one word
   function automatic logic [20:0] rel_target(input logic [20:0] pc, input logic [10:0] n);
      logic [20:0] off;
      off = {{9{n[10]}}, n, 1'b0};
      rel_target = pc + pc_step + off;
   endfunction

   // data address of the bit-set operand
   function automatic logic [11:0] bitset_addr(input logic a, input logic [7:0] f,
                                                input logic ext, input logic [3:0] bank,
                                                input logic [11:0] base);
      if (!a && ext && f <= idx_limit)
         bitset_addr = base + {4'h0, f}; // indexed literal offset
      else if (a)
         bitset_addr = {bank, f}; // bank select chooses bank
      else if (f >= access_split)
         bitset_addr = {access_hi_bank, f}; // access bank upper half
      else
         bitset_addr = {4'h0, f}; // access bank lower half
   endfunction

   logic is_bnc, is_bnn, is_bra, is_bsf;
   // opcode decode
   always_comb begin
      is_bnc = instr_in[15:12] == op_hi_cond && instr_in[11:8] == op_carry_clr;
      is_bnn = instr_in[15:12] == op_hi_cond && instr_in[11:8] == op_neg_clr;
      is_bra = instr_in[15:11] == op_bra_pfx;
      is_bsf = instr_in[15:12] == op_bitset;
   end

   // quarter sequencing, branch decision and pc update
   always_comb begin
      nxt_cur = cur_ff;
      nxt_cur.bs_start = 1'b0;
      nxt_cur.q = cur_ff.q + 2'h1;
      if (cur_ff.q == 2'h0) begin
         // q1: decode
         nxt_cur.take = 1'b0;
         nxt_cur.here = cur_ff.pc;
         if (cur_ff.st == st_exec && instr_valid_in) begin
            if (is_bnc) begin
               nxt_cur.take = !carry_in;
               nxt_cur.offs = {{3{instr_in[7]}}, instr_in[7:0]};
               nxt_cur.target = rel_target(cur_ff.pc, {{3{instr_in[7]}}, instr_in[7:0]});
            end else if (is_bnn) begin
               nxt_cur.take = !negative_in;
               nxt_cur.offs = {{3{instr_in[7]}}, instr_in[7:0]};
               nxt_cur.target = rel_target(cur_ff.pc, {{3{instr_in[7]}}, instr_in[7:0]});
            end else if (is_bra) begin
               nxt_cur.take = 1'b1;
               nxt_cur.offs = instr_in[10:0];
               nxt_cur.target = rel_target(cur_ff.pc, instr_in[10:0]);
            end else if (is_bsf) begin
               nxt_cur.bs_start = 1'b1;
               nxt_cur.bsel = instr_in[pos_bit_hi:pos_bit_lo];
               nxt_cur.addr = bitset_addr(instr_in[pos_access], instr_in[7:0], ext_set_in,
                                          bank_select_value_in, index_base_in);
            end
         end
      end else if (cur_ff.q == q_last) begin
         // q4: write pc, then choose next cycle kind
         case (cur_ff.st)
            st_exec: begin
               if (cur_ff.take) begin
                  nxt_cur.pc = cur_ff.target;
                  nxt_cur.st = st_nop;
               end else begin
                  nxt_cur.pc = cur_ff.pc + pc_step;
               end
            end
            st_nop: begin
               nxt_cur.st = st_exec; // flushed cycle over
            end
            default: begin
               nxt_cur.st = st_exec;
            end
         endcase
      end
   end

   // state register
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         cur_ff <= '{st: st_exec, q: 2'h0, pc: pc_reset, here: pc_reset,
                     target: pc_reset, take: 1'b0, addr: 12'h000, bs_start: 1'b0,
                     bsel: 3'h0, offs: 11'h000};
      end else begin
         cur_ff <= nxt_cur;
      end
   end

   // read-modify-write engine
   bit_set_unit u_bitset (
      .clk_in(clk_in),
      .resetn_in(resetn_in),
      .start_in(cur_ff.bs_start),
      .quarter_in(cur_ff.q),
      .bit_sel_in(cur_ff.bsel),
      .rd_data_in(rd_data_in),
      .rd_en_out(rd_en_out),
      .wr_en_out(wr_en_out),
      .wr_data_out(wr_data_out)
   );

   assign pc_out = cur_ff.pc;
   assign quarter_out = cur_ff.q;
   assign nop_cycle_out = cur_ff.st == st_nop;
   assign data_addr_out = cur_ff.addr;
   assign status_we_out = 1'b0;

   sequence s_taken_q4;
      cur_ff.q == q_last && cur_ff.st == st_exec && cur_ff.take;
   endsequence
   sequence s_nop_cycle;
      nop_cycle_out [*4];
   endsequence

   chk_taken_target: assert property (@(posedge clk_in) disable iff (!resetn_in)
      s_taken_q4 |=> pc_out == $past(cur_ff.here) + pc_step +
                     {{9{$past(cur_ff.offs[10])}}, $past(cur_ff.offs), 1'b0})
      else $error("taken branch pc wrong");
   chk_taken_nop: assert property (@(posedge clk_in) disable iff (!resetn_in)
      s_taken_q4 |=> s_nop_cycle ##1 !nop_cycle_out)
      else $error("taken branch lacks one nop cycle");
   chk_untaken_step: assert property (@(posedge clk_in) disable iff (!resetn_in)
      (cur_ff.q == q_last && cur_ff.st == st_exec && !cur_ff.take)
      |=> pc_out == $past(pc_out) + pc_step && !nop_cycle_out)
      else $error("untaken cycle not one word");
   chk_carry_clear: assert property (@(posedge clk_in) disable iff (!resetn_in)
      (cur_ff.q == 2'h0 && cur_ff.st == st_exec && instr_valid_in && is_bnc)
      |=> cur_ff.take == !$past(carry_in))
      else $error("carry branch decision wrong");
   chk_neg_clear: assert property (@(posedge clk_in) disable iff (!resetn_in)
      (cur_ff.q == 2'h0 && cur_ff.st == st_exec && instr_valid_in && is_bnn)
      |=> cur_ff.take == !$past(negative_in))
      else $error("negative branch decision wrong");
   chk_bra_always: assert property (@(posedge clk_in) disable iff (!resetn_in)
      (cur_ff.q == 2'h0 && cur_ff.st == st_exec && instr_valid_in && is_bra)
      |=> ##3 nop_cycle_out [*4])
      else $error("always branch not two cycles");
   chk_bank_sel: assert property (@(posedge clk_in) disable iff (!resetn_in)
      (cur_ff.q == 2'h0 && cur_ff.st == st_exec && instr_valid_in && is_bsf
       && instr_in[pos_access])
      |=> data_addr_out == {$past(bank_select_value_in), $past(instr_in[7:0])})
      else $error("bank select address wrong");
   chk_indexed_addr: assert property (@(posedge clk_in) disable iff (!resetn_in)
      (cur_ff.q == 2'h0 && cur_ff.st == st_exec && instr_valid_in && is_bsf
       && !instr_in[pos_access] && ext_set_in && instr_in[7:0] <= idx_limit)
      |=> data_addr_out == $past(index_base_in) + {4'h0, $past(instr_in[7:0])})
      else $error("indexed address wrong");
   chk_status_quiet: assert property (@(posedge clk_in) disable iff (!resetn_in)
      !status_we_out)
      else $error("status written");
endmodule // branch_bitset_exec
`default_nettype wire

// ---- verif/branch_and_bit_set_exec_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module branch_and_bit_set_exec_bench
   import branch_bitset_pkg::*;
;
   logic clk_in = 1'b0; // bench clock, starts low
   logic resetn_in, instr_valid_in, carry_in, negative_in, ext_set_in;
   logic [15:0] instr_in; // instruction word
   logic [3:0] bank_select_value_in; // bank select
   logic [11:0] index_base_in; // indexed base
   logic [7:0] rd_data_in, wr_data_out;
   logic [20:0] pc_out;
   logic [1:0] quarter_out;
   logic [11:0] data_addr_out;
   logic nop_cycle_out, rd_en_out, wr_en_out, status_we_out;
   int num_errors, compares;
   // values seen by one instruction run
   logic [20:0] pc0, pcn;
   logic [11:0] addr;
   logic [7:0] wd;
   logic rdp, wrp, stw;
   logic [20:0] nopc;
   branch_bitset_exec branch_bitset_exec_inst (.clk_in(clk_in), .resetn_in(resetn_in),
      .instr_in(instr_in), .instr_valid_in(instr_valid_in), .carry_in(carry_in),
      .negative_in(negative_in), .ext_set_in(ext_set_in),
      .bank_select_value_in(bank_select_value_in), .index_base_in(index_base_in),
      .rd_data_in(rd_data_in), .pc_out(pc_out), .quarter_out(quarter_out),
      .nop_cycle_out(nop_cycle_out), .data_addr_out(data_addr_out), .rd_en_out(rd_en_out),
      .wr_en_out(wr_en_out), .wr_data_out(wr_data_out), .status_we_out(status_we_out));
   // 125 mhz clock, one rising edge per quarter
   always #4 clk_in = ~clk_in;
   // compare and count
   task automatic check(input logic [20:0] seen, input logic [20:0] exp);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   // verdict and end of run
   task automatic conclude();
      $display("compares %0d mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // expected relative target, offset counts words
   function automatic logic [20:0] tgt(input logic [20:0] p, input logic [10:0] off);
      return p + pc_step + {{9{off[10]}}, off, 1'b0};
   endfunction
   // issue one instruction and watch its cycle plus the next one
   task automatic run(input logic [15:0] ins, input logic c, input logic n, input logic ext,
                      input logic [3:0] bank, input logic [7:0] rd);
      int i;
      @(posedge clk_in);
      instr_in <= ins;
      instr_valid_in <= 1'b1;
      carry_in <= c;
      negative_in <= n;
      ext_set_in <= ext;
      bank_select_value_in <= bank;
      rd_data_in <= rd;
      for (i = 0; i < 64; i++) begin
         @(negedge clk_in);
         if (quarter_out === 2'h0 && nop_cycle_out === 1'b0) break;
      end
      if (i == 64) begin
         num_errors++;
         conclude();
      end
      pc0 = pc_out;
      @(posedge clk_in);
      instr_valid_in <= 1'b0;
      @(negedge clk_in);
      check(quarter_out, 21'h1);
      rdp = rd_en_out; // q2 read strobe
      addr = data_addr_out;
      stw = status_we_out;
      @(negedge clk_in);
      rdp = rdp & ~rd_en_out; // strobe lasts one quarter
      wrp = ~wr_en_out;
      @(negedge clk_in);
      wrp = wrp & wr_en_out; // q4 write strobe
      wd = wr_data_out;
      @(negedge clk_in);
      pcn = pc_out;
      nopc = '0;
      repeat (4) begin
         nopc = nopc + (nop_cycle_out === 1'b1);
         stw = stw | status_we_out;
         @(negedge clk_in);
      end
   endtask
   // common judgement of pc, idle cycle, strobes and flags
   task automatic judge(input logic [20:0] epc, input logic taken, input logic rw);
      check(pcn, epc);
      check(nopc, taken ? 21'h4 : 21'h0);
      check({rdp, wrp}, {rw, rw});
      check(stw, 1'b0);
   endtask
   // both flag-clear branches, each flag level, other flag opposite
   task automatic test_cond();
      logic [3:0] op;
      logic [7:0] off;
      for (int k = 0; k < 4; k++) begin
         op = k[1] ? op_neg_clr : op_carry_clr;
         off = k[0] ? 8'h7f : (k[1] ? 8'h05 : 8'h80);
         run({op_hi_cond, op, off}, k[1] ? ~k[0] : k[0], k[1] ? k[0] : ~k[0], 1'b0, 4'h0, 8'h00);
         judge(k[0] ? pc0 + pc_step : tgt(pc0, {{3{off[7]}}, off}), ~k[0], 1'b0);
      end
      $display("test conditional branches done");
   endtask
   // always branch at offset limits, and near-miss opcodes
   task automatic test_always();
      logic [10:0] offs [3];
      offs = '{11'h3ff, 11'h400, 11'h000};
      foreach (offs[i]) begin
         run({op_bra_pfx, offs[i]}, 1'b1, 1'b1, 1'b0, 4'h0, 8'h00);
         judge(tgt(pc0, offs[i]), 1'b1, 1'b0);
      end
      run(16'hd800, 1'b0, 1'b0, 1'b0, 4'h0, 8'h00);
      judge(pc0 + pc_step, 1'b0, 1'b0);
      run(16'he400, 1'b0, 1'b0, 1'b0, 4'h0, 8'h00);
      judge(pc0 + pc_step, 1'b0, 1'b0);
      $display("test always branch done");
   endtask
   // one bit-set with expected address and byte
   task automatic bs(input logic [2:0] b, input logic a, input logic [7:0] f, input logic ext,
                     input logic [3:0] bank, input logic [11:0] base);
      logic [11:0] ea;
      @(posedge clk_in);
      index_base_in <= base;
      if (a) ea = {bank, f};
      else if (ext && f <= idx_limit) ea = base + {4'h0, f};
      else if (f < access_split) ea = {4'h0, f};
      else ea = {access_hi_bank, f};
      run({op_bitset, b, a, f}, 1'b1, 1'b0, ext, bank, 8'h5a);
      judge(pc0 + pc_step, 1'b0, 1'b1);
      check(wd, 8'h5a | (8'h01 << b));
      check(addr, ea);
   endtask
   // every bit number, both access kinds, indexed boundary
   task automatic test_bitset();
      for (int i = 0; i < 8; i++) begin
         bs(i[2:0], 1'b1, 8'h20 + i[7:0], 1'b0, 4'h5, 12'h3a0);
      end
      bs(3'h2, 1'b0, 8'h5f, 1'b0, 4'h5, 12'h3a0);
      bs(3'h5, 1'b0, 8'h60, 1'b0, 4'h5, 12'h3a0);
      bs(3'h0, 1'b0, 8'h5f, 1'b1, 4'h5, 12'hfc0);
      bs(3'h7, 1'b0, 8'h60, 1'b1, 4'h5, 12'h3a0);
      bs(3'h1, 1'b1, 8'h10, 1'b1, 4'h9, 12'h3a0);
      $display("test bit set done");
   endtask
   // reset, then the scenarios
   initial begin
      resetn_in = 1'b0;
      instr_in = 16'h0000;
      instr_valid_in = 1'b0;
      carry_in = 1'b0;
      negative_in = 1'b0;
      ext_set_in = 1'b0;
      bank_select_value_in = 4'h0;
      index_base_in = 12'h000;
      rd_data_in = 8'h00;
      num_errors = 0;
      compares = 0;
      repeat (4) @(posedge clk_in);
      resetn_in <= 1'b1;
      test_cond();
      test_always();
      test_bitset();
      conclude();
   end
endmodule // branch_and_bit_set_exec_bench
`default_nettype wire
